// File: abrpm_cell_sink.sv
// transmit path model: takes offered cells, stalling at random when asked
`timescale 1ns/10ps
module abrpm_cell_sink (
	input wire logic hclk, // clock
	input wire logic hresetn, // reset, active low
	input wire logic stall_en, // allow stalls
	output logic cell_tx_ready // cell taken
);
	logic [3:0] lf, next_lf;
	// small lfsr so stalls land on varied cycles
	always_comb next_lf = {lf[2:0], lf[3] ^ lf[2]};
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lf <= 4'h9;
			cell_tx_ready <= 1'b0;
		end else begin
			lf <= next_lf;
			cell_tx_ready <= !(stall_en && lf[0]);
		end
	end
endmodule // abrpm_cell_sink

// File: abrpm_checker.sv
// concurrent checks on the ports of the abr profile rate manager
`timescale 1ns/10ps
module abrpm_checker (
	input wire logic hclk, // clock
	input wire logic hresetn, // reset, active low
	input wire logic cell_tx_valid, // cell offered
	input wire logic cell_tx_ready, // cell taken
	input wire abrpm_pkg::abrpm_cell_tx_s cell_tx, // offered cell
	input wire logic rm_rx_valid, // rm cell in
	input wire logic rx_cell_valid, // header info in
	input wire abrpm_pkg::abrpm_rx_cell_s rx_cell, // header info
	input wire logic rm_drained, // rm channel emptied
	input wire logic rm_host_valid, // rm cell to host
	input wire logic rxq_append_valid, // queue append
	input wire logic [abrpm_pkg::CW-1:0] rxq_append_chan, // appended channel
	input wire logic cq_wr_valid, // congestion write
	input wire abrpm_pkg::abrpm_cq_entry_s cq_wr // congestion entry
);
	import abrpm_pkg::*;
	logic [11:0] last_ptr, next_last_ptr;
	logic have_last, next_have_last;
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// remember the last entry offset so the next one can be predicted
	always_comb begin
		next_last_ptr = last_ptr;
		next_have_last = have_last;
		if (cq_wr_valid) begin
			next_last_ptr = cq_wr.addr[11:0];
			next_have_last = 1'b1;
		end
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			last_ptr <= 12'h000;
			have_last <= 1'b0;
		end else begin
			last_ptr <= next_last_ptr;
			have_last <= next_have_last;
		end
	end
	sequence append_s;
		rxq_append_valid && rxq_append_chan == RM_CHAN;
	endsequence
	sequence efci_hit_s;
		rx_cell_valid && rx_cell.prio == ABR_PRIO && !rx_cell.efci;
	endsequence
	rm_append_a: assert property (rm_drained |=> append_s)
		else $error("rm drain gave no append");
	append_cause_a: assert property (rxq_append_valid |-> $past(rm_drained))
		else $error("append without drain");
	efci_entry_a: assert property (efci_hit_s |=> cq_wr_valid && cq_wr.data == {24'h0,
		$past(rx_cell.prio), $past(rx_cell.cong), 1'b0, $past(rx_cell.chan)})
		else $error("efci zero entry wrong");
	efci_one_a: assert property (rx_cell_valid && rx_cell.prio == ABR_PRIO && rx_cell.efci
		|=> !cq_wr_valid) else $error("entry for efci one");
	entry_cause_a: assert property (cq_wr_valid |-> $past(rx_cell_valid))
		else $error("entry without cell");
	cq_step_a: assert property (cq_wr_valid |-> cq_wr.addr[11:0] ==
		(have_last ? last_ptr + 12'h004 : 12'h000)) else $error("queue offset step wrong");
	cq_word_a: assert property (cq_wr_valid |-> cq_wr.addr[1:0] == 2'h0
		&& cq_wr.data[31:8] == 24'h0) else $error("entry not one word");
	rm_cause_a: assert property (rm_host_valid |-> $past(rm_rx_valid))
		else $error("rm to host without rm in");
	tx_hold_a: assert property (cell_tx_valid && !cell_tx_ready |=> cell_tx_valid
		&& $stable(cell_tx)) else $error("offered cell changed");
endmodule // abrpm_checker

// File: abrpm_pkg.sv
// constants, register layouts and carrier types of the abr profile rate manager
package abrpm_pkg;

	// ------------------------------------------------------------
	// sizes
	// ------------------------------------------------------------
	localparam int NCH = 16;
	localparam int CW = 4;
	localparam int NPROF = 32;
	localparam int PW = 5;
	localparam int MAXCH = NCH - 1;
	localparam logic [CW:0] LIST_MAX = 5'(MAXCH + 1 - 4);
	localparam logic [PW-1:0] PROF_SLOWEST = 5'h1f;
	localparam logic [CW-1:0] RM_CHAN = 4'h1;
	localparam logic [1:0] ABR_PRIO = 2'h3;

	// ------------------------------------------------------------
	// register byte offsets and reset values
	// ------------------------------------------------------------
	localparam logic [11:0] OFF_CTRL = 12'h000;
	localparam logic [11:0] OFF_RELOC = 12'h004;
	localparam logic [11:0] OFF_CQ_BASE = 12'h008;
	localparam logic [11:0] OFF_CQ_PTR = 12'h00c;
	localparam logic [11:0] OFF_PROF_CFG = 12'h010;
	localparam logic [11:0] OFF_CH_CFG = 12'h014;
	localparam logic [11:0] OFF_CH_STAT = 12'h018;
	localparam logic [1:0] CTRL_RST = 2'h1;
	localparam int CTRL_AUTO = 0;
	localparam int CTRL_RM_FWD = 1;
	localparam int CQ_SPAN_BITS = 12;
	localparam logic [CQ_SPAN_BITS-1:0] CQ_ENTRY_BYTES = 12'h004;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {KIND_CBR, KIND_VBR, KIND_ABR} abrpm_kind_e;

	typedef struct packed {
		abrpm_kind_e kind;
		logic [7:0] peak;
		logic [PW-1:0] inc_target;
		logic [2:0] adr_dec;
		logic [2:0] nrm_dec;
	} abrpm_prof_s;

	typedef struct packed {
		logic [PW-1:0] prof, init, minp, maxp, saved;
		logic [5:0] adr_rld, nrm_rld, adr_cnt, nrm_cnt;
		logic [7:0] pace;
		logic attached, off_list, rm_rcv, send_rm, efci0_sent, cong_last;
	} abrpm_ch_s;

	typedef struct packed {
		logic [4:0] rsv;
		logic [2:0] nrm_dec;
		logic [2:0] adr_dec;
		logic [PW-1:0] inc_target;
		logic [7:0] peak;
		logic [1:0] kind;
		logic rsv2;
		logic [PW-1:0] idx;
	} abrpm_prof_cfg_s;

	typedef struct packed {
		logic attach;
		logic [5:0] nrm, adr;
		logic [PW-1:0] maxp, minp, init;
		logic [CW-1:0] chan;
	} abrpm_ch_cfg_s;

	typedef struct packed {
		logic [18:0] rsv;
		logic [PW-1:0] target;
		logic [3:0] rsv2;
		logic [CW-1:0] chan;
	} abrpm_reloc_s;

	typedef struct packed {
		logic [CW-1:0] chan;
		logic efci;
		logic rm;
	} abrpm_cell_tx_s;

	typedef struct packed {
		logic [CW-1:0] chan;
		logic [1:0] prio;
		logic efci;
		logic cong;
	} abrpm_rx_cell_s;

	typedef struct packed {
		logic [31:0] addr;
		logic [31:0] data;
	} abrpm_cq_entry_s;

endpackage

// File: abrpm_rate_manager.sv
// abr profile rate manager: profile tables, channel movement, congestion queue, ahb-lite regs
`timescale 1ns/10ps
// ------------------------------------------------------------
// ------------------------------------------------------------
module abrpm_rate_manager (
	input wire logic hclk, // system clock
	input wire logic hresetn, // async reset, active low
	input wire logic hsel, // slave select
	input wire logic [31:0] haddr, // byte address
	input wire logic [1:0] htrans, // transfer type
	input wire logic hwrite, // write strobe
	input wire logic [2:0] hsize, // word only
	input wire logic [31:0] hwdata, // write data
	input wire logic hready, // bus ready
	output logic [31:0] hrdata, // read data
	output logic hreadyout, // slave ready
	output logic hresp, // always okay
	input wire logic [abrpm_pkg::NCH-1:0] has_data, // channel has cells queued
	input wire logic cell_tx_ready, // transmit path takes a cell
	output logic cell_tx_valid, // cell offered
	output abrpm_pkg::abrpm_cell_tx_s cell_tx, // cell channel and flags
	input wire logic rm_rx_valid, // rm cell received
	input wire logic [abrpm_pkg::CW-1:0] rm_rx_chan, // its channel
	input wire logic rx_cell_valid, // received cell header info
	input wire abrpm_pkg::abrpm_rx_cell_s rx_cell, // channel, prio, efci, cong
	input wire logic rm_drained, // rm channel emptied to host
	output logic rm_host_valid, // rm cell to host
	output logic [abrpm_pkg::CW-1:0] rm_host_chan, // physical channel it goes on
	output logic rxq_append_valid, // receive queue append
	output logic [abrpm_pkg::CW-1:0] rxq_append_chan, // appended channel
	output logic cq_wr_valid, // congestion entry write
	output abrpm_pkg::abrpm_cq_entry_s cq_wr // local ram address and entry
);
	import abrpm_pkg::*;

	// ------------------------------------------------------------
	// bus slave
	// ------------------------------------------------------------
	logic a_valid, next_a_valid, a_write, next_a_write;
	logic [11:0] a_addr, next_a_addr;
	logic [1:0] ctrl, next_ctrl;
	logic [31:CQ_SPAN_BITS] cq_base, next_cq_base;
	logic [PW-1:0] prof_sel, next_prof_sel;
	logic [CW-1:0] ch_sel, next_ch_sel;
	logic [31:0] next_hrdata;
	logic wr_reloc, wr_prof, wr_ch;
	logic [CQ_SPAN_BITS-1:0] cq_ptr, next_cq_ptr;
	abrpm_prof_s prof [NPROF];
	abrpm_prof_s next_prof [NPROF];
	abrpm_ch_s ch [NCH];
	abrpm_ch_s next_ch [NCH];

	// read view of one profile in its configuration layout
	function automatic logic [31:0] prof_view(input abrpm_prof_s p, input logic [PW-1:0] i);
		abrpm_prof_cfg_s v;
		v = '0;
		v.nrm_dec = p.nrm_dec;
		v.adr_dec = p.adr_dec;
		v.inc_target = p.inc_target;
		v.peak = p.peak;
		v.kind = p.kind;
		v.idx = i;
		return v;
	endfunction

	// address phase captured; read data prepared so the data phase has no wait
	always_comb begin
		next_a_valid = hsel && htrans[1] && hready;
		next_a_write = hwrite;
		next_a_addr = haddr[11:0];
		next_hrdata = hrdata;
		if (hsel && htrans[1] && hready && !hwrite) begin
			unique case (haddr[11:0])
				OFF_CTRL: next_hrdata = {30'h0, ctrl};
				OFF_CQ_BASE: next_hrdata = {cq_base, 12'h000};
				OFF_CQ_PTR: next_hrdata = {20'h0, cq_ptr};
				OFF_PROF_CFG: next_hrdata = prof_view(prof[prof_sel], prof_sel);
				OFF_CH_STAT: next_hrdata = {4'h0, ch[ch_sel].cong_last, ch[ch_sel].send_rm,
					ch[ch_sel].off_list, ch[ch_sel].efci0_sent, ch[ch_sel].rm_rcv, 2'h0,
					ch[ch_sel].saved, 7'h00, ch[ch_sel].attached, 3'h0, ch[ch_sel].prof};
				default: next_hrdata = 32'h0000_0000;
			endcase
		end
		wr_reloc = a_valid && a_write && a_addr == OFF_RELOC;
		wr_prof = a_valid && a_write && a_addr == OFF_PROF_CFG;
		wr_ch = a_valid && a_write && a_addr == OFF_CH_CFG;
		next_ctrl = (a_valid && a_write && a_addr == OFF_CTRL) ? hwdata[1:0] : ctrl;
		next_cq_base = (a_valid && a_write && a_addr == OFF_CQ_BASE) ?
			hwdata[31:CQ_SPAN_BITS] : cq_base;
		next_prof_sel = wr_prof ? hwdata[PW-1:0] : prof_sel;
		next_ch_sel = wr_ch ? hwdata[CW-1:0] : ch_sel;
	end

	// bus registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			a_valid <= 1'b0;
			a_write <= 1'b0;
			a_addr <= 12'h000;
			hrdata <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			ctrl <= CTRL_RST;
			cq_base <= '0;
			prof_sel <= '0;
			ch_sel <= '0;
		end else begin
			a_valid <= next_a_valid;
			a_write <= next_a_write;
			a_addr <= next_a_addr;
			hrdata <= next_hrdata;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			ctrl <= next_ctrl;
			cq_base <= next_cq_base;
			prof_sel <= next_prof_sel;
			ch_sel <= next_ch_sel;
		end
	end

	// ------------------------------------------------------------
	// profile table
	// ------------------------------------------------------------
	// host writes one whole entry per access
	always_comb begin
		abrpm_prof_cfg_s w;
		w = abrpm_prof_cfg_s'(hwdata);
		for (int i = 0; i < NPROF; i++) begin
			next_prof[i] = prof[i];
		end
		if (wr_prof) begin
			next_prof[w.idx].kind = abrpm_kind_e'(w.kind);
			next_prof[w.idx].peak = w.peak;
			next_prof[w.idx].inc_target = w.inc_target;
			next_prof[w.idx].adr_dec = w.adr_dec;
			next_prof[w.idx].nrm_dec = w.nrm_dec;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < NPROF; i++) begin
				prof[i] <= '0;
			end
		end else begin
			for (int i = 0; i < NPROF; i++) begin
				prof[i] <= next_prof[i];
			end
		end
	end

	// ------------------------------------------------------------
	// channel movement and transmit scheduling
	// ------------------------------------------------------------
	logic [CW:0] list_cnt [NPROF];
	logic [CW-1:0] scan_ptr, next_scan_ptr;
	logic next_tx_valid;
	abrpm_cell_tx_s next_tx;

	// occupancy of each profile list, for the length ceiling
	always_comb begin
		for (int k = 0; k < NPROF; k++) begin
			list_cnt[k] = '0;
			for (int i = 0; i < NCH; i++) begin
				if (ch[i].attached && ch[i].prof == PW'(k)) begin
					list_cnt[k] = 5'(list_cnt[k] + 5'h01);
				end
			end
		end
	end

	// scan one channel per cycle, then apply events; later writes win, so sets beat clears
	always_comb begin
		abrpm_ch_s c;
		abrpm_prof_s p;
		abrpm_ch_cfg_s cfg;
		abrpm_reloc_s rl;
		logic [PW-1:0] tgt;
		logic stall, abr;
		c = ch[scan_ptr];
		p = prof[c.prof];
		cfg = abrpm_ch_cfg_s'(hwdata);
		rl = abrpm_reloc_s'(hwdata);
		tgt = c.saved;
		abr = p.kind == KIND_ABR;
		stall = cell_tx_valid && !cell_tx_ready;
		next_tx_valid = stall;
		next_tx = cell_tx;
		next_scan_ptr = stall ? scan_ptr : CW'(scan_ptr + 4'h1);
		for (int i = 0; i < NCH; i++) begin
			next_ch[i] = ch[i];
			if (ch[i].pace != 8'h00) begin
				next_ch[i].pace = 8'(ch[i].pace - 8'h01);
			end
		end
		if (!stall) begin
			if (c.attached && abr && c.rm_rcv) begin
				if (tgt < c.maxp) begin
					tgt = c.maxp;
				end
				if (list_cnt[tgt] < LIST_MAX) begin
					c.prof = tgt;
					c.adr_cnt = c.adr_rld;
				end
				c.rm_rcv = 1'b0;
			end else if (c.attached && c.pace == 8'h00 && has_data[scan_ptr]) begin
				// channel one is paced like any other by its own profile
				next_tx_valid = 1'b1;
				next_tx.chan = scan_ptr;
				next_tx.rm = c.send_rm;
				next_tx.efci = 1'b0;
				c.send_rm = 1'b0;
				c.pace = p.peak;
				if (abr) begin
					next_tx.efci = 1'b1;
					if (c.nrm_cnt <= 6'(p.nrm_dec)) begin
						next_tx.efci = 1'b0;
						c.nrm_cnt = c.nrm_rld;
						c.saved = p.inc_target;
						c.efci0_sent = 1'b1;
					end else begin
						c.nrm_cnt = 6'(c.nrm_cnt - 6'(p.nrm_dec));
					end
					if (c.adr_cnt <= 6'(p.adr_dec)) begin
						c.adr_cnt = c.adr_rld;
						if (c.prof < c.minp && c.prof != PROF_SLOWEST &&
							list_cnt[5'(c.prof + 5'h01)] < LIST_MAX) begin
							c.prof = 5'(c.prof + 5'h01);
						end
					end else begin
						c.adr_cnt = 6'(c.adr_cnt - 6'(p.adr_dec));
					end
				end
			end else if (c.attached && c.pace == 8'h00 && abr) begin
				// idle abr channel; cbr and vbr channels stay put
				if (c.prof < c.init) begin
					if (c.prof < c.minp && list_cnt[5'(c.prof + 5'h01)] < LIST_MAX) begin
						c.prof = 5'(c.prof + 5'h01);
					end
				end else begin
					c.attached = 1'b0;
					c.off_list = 1'b1;
				end
			end else if (c.off_list && has_data[scan_ptr] && list_cnt[c.init] < LIST_MAX) begin
				c.prof = c.init;
				c.attached = 1'b1;
				c.off_list = 1'b0;
				c.adr_cnt = c.adr_rld;
				c.nrm_cnt = c.nrm_rld;
			end
			c.pace = (ch[scan_ptr].pace != 8'h00) ? next_ch[scan_ptr].pace : c.pace;
			next_ch[scan_ptr] = c;
		end
		// host configuration and relocation; rests on the scan only moving abr
		if (wr_ch) begin
			next_ch[cfg.chan] = '0;
			next_ch[cfg.chan].init = cfg.init;
			next_ch[cfg.chan].prof = cfg.init;
			next_ch[cfg.chan].minp = cfg.minp;
			next_ch[cfg.chan].maxp = cfg.maxp;
			next_ch[cfg.chan].saved = cfg.init;
			next_ch[cfg.chan].adr_rld = cfg.adr;
			next_ch[cfg.chan].adr_cnt = cfg.adr;
			next_ch[cfg.chan].nrm_rld = cfg.nrm;
			next_ch[cfg.chan].nrm_cnt = cfg.nrm;
			next_ch[cfg.chan].attached = cfg.attach && list_cnt[cfg.init] < LIST_MAX;
		end
		if (wr_reloc && list_cnt[rl.target] < LIST_MAX) begin
			next_ch[rl.chan].prof = rl.target;
		end
		// received cells mark the channel last so an event is never lost
		if (rm_rx_valid && ctrl[CTRL_AUTO]) begin
			next_ch[rm_rx_chan].rm_rcv = 1'b1;
		end
		if (rx_cell_valid) begin
			next_ch[rx_cell.chan].cong_last = rx_cell.cong;
			if (ctrl[CTRL_AUTO] && rx_cell.prio == ABR_PRIO && !rx_cell.efci) begin
				next_ch[rx_cell.chan].send_rm = 1'b1;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < NCH; i++) begin
				ch[i] <= '0;
			end
			scan_ptr <= '0;
			cell_tx_valid <= 1'b0;
			cell_tx <= '0;
		end else begin
			for (int i = 0; i < NCH; i++) begin
				ch[i] <= next_ch[i];
			end
			scan_ptr <= next_scan_ptr;
			cell_tx_valid <= next_tx_valid;
			cell_tx <= next_tx;
		end
	end

	// ------------------------------------------------------------
	// congestion queue, rm forwarding, receive queue append
	// ------------------------------------------------------------
	logic next_cq_wr_valid, next_rm_host_valid, next_rxq_valid;
	abrpm_cq_entry_s next_cq_wr;
	logic [CW-1:0] next_rm_host_chan;

	// queue pointer wraps inside the 4 kb span; the host drains entries one at a time
	always_comb begin
		next_cq_wr_valid = 1'b0;
		next_cq_wr = cq_wr;
		next_cq_ptr = cq_ptr;
		if (rx_cell_valid && ((rx_cell.prio != ABR_PRIO &&
			rx_cell.cong != ch[rx_cell.chan].cong_last) ||
			(rx_cell.prio == ABR_PRIO && !rx_cell.efci))) begin
			next_cq_wr_valid = 1'b1;
			next_cq_wr.addr = {cq_base, cq_ptr};
			next_cq_wr.data = {24'h000000, rx_cell.prio, rx_cell.cong, rx_cell.efci,
				rx_cell.chan};
			next_cq_ptr = CQ_SPAN_BITS'(cq_ptr + CQ_ENTRY_BYTES);
		end
		// auto mode forwards only when enabled; host mode always uses channel one
		next_rm_host_valid = rm_rx_valid && (!ctrl[CTRL_AUTO] || ctrl[CTRL_RM_FWD]);
		next_rm_host_chan = ctrl[CTRL_AUTO] ? rm_rx_chan : RM_CHAN;
		next_rxq_valid = rm_drained;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cq_wr_valid <= 1'b0;
			cq_wr <= '0;
			cq_ptr <= '0;
			rm_host_valid <= 1'b0;
			rm_host_chan <= '0;
			rxq_append_valid <= 1'b0;
			rxq_append_chan <= RM_CHAN;
		end else begin
			cq_wr_valid <= next_cq_wr_valid;
			cq_wr <= next_cq_wr;
			cq_ptr <= next_cq_ptr;
			rm_host_valid <= next_rm_host_valid;
			rm_host_chan <= next_rm_host_chan;
			rxq_append_valid <= next_rxq_valid;
			rxq_append_chan <= RM_CHAN;
		end
	end

endmodule // abrpm_rate_manager

// File: tb_abr_profile_rate_manager.sv
// self-checking bench of the abr profile rate manager
`timescale 1ns/10ps
`define CHK(n, e, g) begin check_count++; if ((e) !== (g)) begin miscompares++; \
	$display("Error %s exp %h got %h", n, e, g); end end
module tb_abr_profile_rate_manager;
	import abrpm_pkg::*;
	logic hclk, hresetn, hsel, hwrite, hready, hresp, cell_tx_ready, cell_tx_valid, stall_en;
	logic [31:0] haddr, hwdata, hrdata, d, cfg;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [15:0] has_data, rnd;
	logic rm_rx_valid, rx_cell_valid, rm_drained, rm_host_valid, rxq_append_valid, cq_wr_valid;
	logic [3:0] rm_rx_chan, rm_host_chan, rxq_append_chan, ce_chan;
	logic [19:0] base;
	logic [11:0] ptr;
	abrpm_cell_tx_s cell_tx;
	abrpm_rx_cell_s rx_cell;
	abrpm_cq_entry_s cq_wr, ce;
	abrpm_cq_entry_s exp_cq[$];
	logic [3:0] exp_rm[$], exp_rxq[$];
	int miscompares = 0, check_count = 0, cyc = 0, cell_cnt = 0, efci0_cnt = 0;
	logic hreadyout;
	assign hready = hreadyout;
	abrpm_rate_manager dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .has_data(has_data),
		.cell_tx_ready(cell_tx_ready), .cell_tx_valid(cell_tx_valid), .cell_tx(cell_tx),
		.rm_rx_valid(rm_rx_valid), .rm_rx_chan(rm_rx_chan), .rx_cell_valid(rx_cell_valid),
		.rx_cell(rx_cell), .rm_drained(rm_drained), .rm_host_valid(rm_host_valid),
		.rm_host_chan(rm_host_chan), .rxq_append_valid(rxq_append_valid),
		.rxq_append_chan(rxq_append_chan), .cq_wr_valid(cq_wr_valid), .cq_wr(cq_wr));
	abrpm_cell_sink sink (.hclk(hclk), .hresetn(hresetn), .stall_en(stall_en),
		.cell_tx_ready(cell_tx_ready));
	function automatic logic [15:0] lfsr(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	task final_report;
		if (miscompares == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// ------------------------------------------------------------
	// ahb-lite single word transfers
	// ------------------------------------------------------------
	task ahb(input logic wr, input logic [11:0] a, input logic [31:0] w, output logic [31:0] r);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {20'h0, a};
		hwrite <= wr;
		htrans <= 2'b10;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwdata <= w;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		r = hrdata;
	endtask
	task rx(input logic [3:0] c, input logic [1:0] p, input logic e, g, input bit hit);
		@(posedge hclk);
		rx_cell_valid <= 1'b1;
		rx_cell <= {c, p, e, g};
		if (hit) begin
			exp_cq.push_back({base, ptr, 24'h0, p, g, e, c});
			ptr = ptr + 12'h004;
		end
		@(posedge hclk);
		rx_cell_valid <= 1'b0;
	endtask
	task rm_in(input logic [3:0] c, input logic [3:0] host_c);
		@(posedge hclk);
		rm_rx_valid <= 1'b1;
		rm_rx_chan <= c;
		exp_rm.push_back(host_c);
		@(posedge hclk);
		rm_rx_valid <= 1'b0;
	endtask
	// clock, and a hang limit that ends the run
	initial begin
		hclk = 1'b0;
		forever #25 hclk = ~hclk;
	end
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			final_report();
		end
	end
	// output watcher: each queue, rm and append result is matched against the oldest note; each taken cell against channel 5
	always @(posedge hclk) begin
		if (cq_wr_valid === 1'b1) begin
			ce = exp_cq.size() ? exp_cq.pop_front() : '0;
			`CHK("cq_wr", ce, cq_wr)
		end
		if (rm_host_valid === 1'b1) begin
			ce_chan = exp_rm.size() ? exp_rm.pop_front() : 4'h0;
			`CHK("rm_host_chan", ce_chan, rm_host_chan)
		end
		if (rxq_append_valid === 1'b1) begin
			ce_chan = exp_rxq.size() ? exp_rxq.pop_front() : 4'h0;
			`CHK("rxq_append_chan", ce_chan, rxq_append_chan)
		end
		if (cell_tx_valid === 1'b1 && cell_tx_ready === 1'b1) begin
			`CHK("cell_chan", 4'h5, cell_tx.chan)
			if (cell_cnt < 6 && cell_tx.efci === 1'b0) efci0_cnt++;
			cell_cnt++;
		end
	end
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		hresetn = 1'b0; hsel = 1'b0; haddr = '0; htrans = 2'b00; hwrite = 1'b0;
		hsize = 3'h2; hwdata = '0; has_data = '0; rm_rx_valid = 1'b0; rm_rx_chan = '0;
		rx_cell_valid = 1'b0; rx_cell = '0; rm_drained = 1'b0; stall_en = 1'b0;
		rnd = 16'h3702; ptr = 12'h000;
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		ahb(1'b0, OFF_CTRL, 32'h0, d);
		`CHK("ctrl", 32'h1, d)
		ahb(1'b0, OFF_CQ_PTR, 32'h0, d);
		`CHK("cq_ptr", 32'h0, d)
		ahb(1'b1, 12'h040, 32'hffffffff, d);
		ahb(1'b0, 12'h040, 32'h0, d);
		`CHK("unmapped", 32'h0, d)
		rnd = lfsr(rnd);
		base = {rnd, 4'hf};
		ahb(1'b1, OFF_CQ_BASE, {rnd, 16'hffff}, d);
		ahb(1'b0, OFF_CQ_BASE, 32'h0, d);
		`CHK("cq_base", {base, 12'h000}, d)
		// abr profiles 18..22, target 18, decrements of one
		for (int i = 18; i <= 22; i++) ahb(1'b1, OFF_PROF_CFG, {11'h009, 5'h12, 8'h04, 3'h4, 5'(i)}, d);
		ahb(1'b0, OFF_PROF_CFG, 32'h0, d);
		`CHK("prof_cfg", {11'h009, 5'h12, 8'h04, 3'h4, 5'h16}, d)
		ahb(1'b1, OFF_CTRL, 32'h3, d);
		cfg = {1'b1, 6'h3, 6'h3f, 5'h12, 5'h16, 5'h14, 4'h5};
		ahb(1'b1, OFF_CH_CFG, cfg, d);
		ahb(1'b1, OFF_RELOC, {19'h0, 5'h13, 4'h0, 4'h5}, d);
		ahb(1'b0, OFF_CH_STAT, 32'h0, d);
		`CHK("reloc", 9'h113, d[8:0])
		// six cells at adr count two, then the data runs out
		cfg[24:19] = 6'h2;
		ahb(1'b1, OFF_CH_CFG, cfg, d);
		stall_en <= 1'b1;
		has_data <= 16'h0020;
		while (cell_cnt < 6) @(posedge hclk);
		has_data <= 16'h0000;
		repeat (400) @(posedge hclk);
		ahb(1'b0, OFF_CH_STAT, 32'h0, d);
		`CHK("stat_low", 12'he56, {d[25:24], d[20:16], d[4:0]})
		`CHK("efci0", 2, efci0_cnt)
		has_data <= 16'h0020;
		repeat (40) @(posedge hclk);
		ahb(1'b0, OFF_CH_STAT, 32'h0, d);
		`CHK("reattach", 2'h1, {d[25], d[8]})
		rm_in(4'h5, 4'h5);
		has_data <= 16'h0000;
		repeat (400) @(posedge hclk);
		ahb(1'b0, OFF_CH_STAT, 32'h0, d);
		`CHK("stat_idle", 6'h34, {d[25], d[4:0]})
		// congestion entries: efci zero on prio 3, cong changes on prio 1
		repeat (4) begin
			rnd = lfsr(rnd);
			rx({1'b1, rnd[2:0]}, 2'h3, 1'b0, rnd[4], 1'b1);
		end
		rx(4'h7, 2'h3, 1'b1, 1'b0, 1'b0);
		rx(4'h7, 2'h1, 1'b0, 1'b1, 1'b1);
		rx(4'h7, 2'h1, 1'b0, 1'b1, 1'b0);
		rx(4'h7, 2'h1, 1'b1, 1'b0, 1'b1);
		ahb(1'b0, OFF_CQ_PTR, 32'h0, d);
		`CHK("cq_ptr_end", {20'h0, ptr}, d)
		@(posedge hclk);
		rm_drained <= 1'b1;
		exp_rxq.push_back(RM_CHAN);
		@(posedge hclk);
		rm_drained <= 1'b0;
		ahb(1'b1, OFF_CTRL, 32'h0, d);
		rm_in(4'h9, RM_CHAN);
		repeat (5) @(posedge hclk);
		`CHK("pending", 0, exp_cq.size() + exp_rm.size() + exp_rxq.size())
		final_report();
	end
endmodule // tb_abr_profile_rate_manager
bind abrpm_rate_manager abrpm_checker chk (.hclk(hclk), .hresetn(hresetn),
	.cell_tx_valid(cell_tx_valid), .cell_tx_ready(cell_tx_ready), .cell_tx(cell_tx),
	.rm_rx_valid(rm_rx_valid), .rx_cell_valid(rx_cell_valid), .rx_cell(rx_cell),
	.rm_drained(rm_drained), .rm_host_valid(rm_host_valid), .rxq_append_valid(rxq_append_valid),
	.rxq_append_chan(rxq_append_chan), .cq_wr_valid(cq_wr_valid), .cq_wr(cq_wr));
